//--- ccg_pkg.sv
// constants and types for the code protection and configuration gate
`default_nettype none

package ccg_pkg;

    // ------------------------------------------------------------------
    // word sizes
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W   = 12;
    localparam int unsigned WORD_W   = 12;
    localparam int unsigned SER_W    = 14;
    localparam int unsigned CMD_W    = 6;
    localparam int unsigned CNT_W    = 4;
    localparam int unsigned ID_WORDS = 4;

    // ------------------------------------------------------------------
    // addresses and the configuration word layout
    // ------------------------------------------------------------------
    localparam logic [11:0] CFG_ADDR   = 12'hFFF;
    localparam logic [11:0] ADDR_RESET = 12'hFFF;
    localparam logic [11:0] ADDR_STEP  = 12'h001;
    localparam logic [11:0] UNPROT_TOP = 12'h03F;
    localparam logic [11:0] CFG_BLANK  = 12'hFFF;
    localparam logic [11:0] WORD_ZERO  = 12'h000;
    localparam int unsigned MASTER_CLEAR_PIN_EN_BIT = 4;
    localparam int unsigned PROTECT_BIT = 3;
    localparam int unsigned WDOG_EN_BIT = 2;
    localparam int unsigned OSC_HI_BIT  = 1;
    localparam int unsigned OSC_LO_BIT  = 0;
    localparam logic        BIT_PROGRAMMED = 1'b0;

    // oscillator select encodings
    localparam logic [1:0] OSC_EXT_RC = 2'h3;
    localparam logic [1:0] OSC_INT_RC = 2'h2;
    localparam logic [1:0] OSC_XTAL   = 2'h1;
    localparam logic [1:0] OSC_LP_XT  = 2'h0;

    // ------------------------------------------------------------------
    // serial commands, six bits
    // ------------------------------------------------------------------
    localparam logic [5:0] CMD_LOAD  = 6'h02;
    localparam logic [5:0] CMD_READ  = 6'h04;
    localparam logic [5:0] CMD_INC   = 6'h06;
    localparam logic [5:0] CMD_BEGIN = 6'h08;
    localparam logic [5:0] CMD_END   = 6'h0E;

    // clock cycle counts within a frame
    localparam logic [3:0] CMD_LAST   = 4'h5;
    localparam logic [3:0] DATA_FIRST = 4'h1;
    localparam logic [3:0] DATA_LAST  = 4'hE;
    localparam logic [3:0] FRAME_LAST = 4'hF;
    localparam logic [3:0] CNT_ZERO   = 4'h0;
    localparam logic [3:0] CNT_STEP   = 4'h1;

    typedef enum logic [1:0] {
        CCG_ST_CMD,
        CCG_ST_LOAD,
        CCG_ST_READ
    } ccg_state_e;

endpackage : ccg_pkg

`default_nettype wire

//--- ccg_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none

module ccg_sync #(
    parameter int unsigned      WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // clock and reset
    input  wire logic             i_clock,
    input  wire logic             i_rst_n,
    // asynchronous side
    input  wire logic [WIDTH-1:0] i_async,
    // synchronous side
    output logic      [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_ff;

    // first stage feeds only the second
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            meta_ff <= RESET_VAL;
            o_sync  <= RESET_VAL;
        end else begin
            meta_ff <= i_async;
            o_sync  <= meta_ff;
        end
    end

endmodule : ccg_sync

`default_nettype wire

//--- ccg_access_gate.sv
// address region decode and protection check
`timescale 1ns/1ps
`default_nettype none

module ccg_access_gate #(
    parameter int unsigned PROG_WORDS = 512,
    parameter bit          HAS_CAL    = 1'b1
) (
    // current access
    input  wire logic [11:0] i_addr,
    input  wire logic        i_code_protect_bit,
    // decoded region
    output logic             o_is_cfg,
    output logic             o_is_prog,
    output logic             o_is_id,
    // verdict
    output logic             o_access_ok
);

    localparam logic [11:0] PROG_END = 12'(PROG_WORDS);
    localparam logic [11:0] ID_END   = 12'(PROG_WORDS + ccg_pkg::ID_WORDS);
    // the calibration word at the top stays open when present
    localparam logic [11:0] PROT_TOP = HAS_CAL ? 12'(PROG_WORDS - 2)
                                               : 12'(PROG_WORDS - 1);

    wire prot_on  = (i_code_protect_bit == ccg_pkg::BIT_PROGRAMMED);
    wire in_range = (i_addr > ccg_pkg::UNPROT_TOP)
                 && (i_addr <= PROT_TOP);
    wire is_prot  = prot_on && o_is_prog && in_range;

    // region decode; reserved space is never accessible
    assign o_is_cfg    = (i_addr == ccg_pkg::CFG_ADDR);
    assign o_is_prog   = (i_addr < PROG_END);
    assign o_is_id     = (i_addr >= PROG_END) && (i_addr < ID_END);
    assign o_access_ok = !is_prot && (o_is_cfg || o_is_prog || o_is_id);

endmodule : ccg_access_gate

`default_nettype wire

//--- ccg_top.sv
// serial program port, configuration word and protection gating
`timescale 1ns/1ps
`default_nettype none

// Operation
// - programmed bit reads zero, blank bit one
// - bit 4 enables external master clear pin
// - bit 3 zero turns code protection on
// - bit 2 enables the watchdog timer
// - bits 1:0 pick the oscillator source
// - words 0x000 to 0x03F always accessible
// - protected reads return all zeros
// - protected writes leave contents unchanged
// - configuration word always readable and writable
// - calibration word stays open when present
// - protected range ends below calibration word
// - four id words always accessible
// - unprotected part fully readable and writable
// - address starts at 0xFFF, wraps to zero
// - serial read word has two zero msbs
module ccg_top #(
    parameter int unsigned PROG_WORDS = 512,
    parameter bit          HAS_CAL    = 1'b1
) (
    // clock and reset (reset is the program mode entry)
    input  wire logic       i_clock,
    input  wire logic       i_rst_n,
    // serial program port pins
    input  wire logic       i_prog_clk,
    input  wire logic       i_prog_data,
    output logic            o_prog_data,
    output logic            o_prog_data_oe_n,
    // master clear pin and resulting core reset
    input  wire logic       i_master_clear_pin_n,
    output logic            o_core_reset_n,
    // decoded configuration
    output logic            o_master_clear_pin_enable,
    output logic            o_code_protect_active,
    output logic            o_watchdog_enable,
    output logic [1:0]      o_oscillator_select_field,
    output logic            o_osc_ext_rc,
    output logic            o_osc_int_rc,
    output logic            o_crystal_osc_mode,
    output logic            o_low_power_crystal_mode,
    // programming status
    output logic [11:0]     o_address,
    output logic            o_prog_pulse,
    output logic            o_access_denied
);

    localparam int unsigned PIDX_W = $clog2(PROG_WORDS);

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [2:0] pin_sync;

    // master clear idles high, so it resets high
    ccg_sync #(
        .WIDTH     (3),
        .RESET_VAL (3'h4)
    ) u_sync (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .i_async ({i_master_clear_pin_n, i_prog_data, i_prog_clk}),
        .o_sync  (pin_sync)
    );

    wire sclk_s  = pin_sync[0];
    wire sdat_s  = pin_sync[1];
    wire master_clear_pin_ns = pin_sync[2];

    // clock edge detect on the synchronised level only
    logic sclk_d_ff;

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            sclk_d_ff <= 1'b0;
        end else begin
            sclk_d_ff <= sclk_s;
        end
    end

    wire sclk_fall = sclk_d_ff && !sclk_s;
    wire sclk_rise = !sclk_d_ff && sclk_s;

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    logic [11:0] prog_mem [0:PROG_WORDS-1];
    logic [11:0] id_mem   [0:ccg_pkg::ID_WORDS-1];
    logic [11:0] cfg_ff;

    // ------------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------------
    ccg_pkg::ccg_state_e state_ff;
    ccg_pkg::ccg_state_e nxt_state;
    logic [3:0]          cnt_ff;
    logic [3:0]          nxt_cnt;
    logic [5:0]          cmd_ff;
    logic [5:0]          nxt_cmd;
    logic [11:0]         addr_ff;
    logic [11:0]         nxt_addr;
    logic [13:0]         load_ff;
    logic [13:0]         nxt_load;
    logic [13:0]         shift_ff;
    logic [13:0]         nxt_shift;
    logic                dout_ff;
    logic                nxt_dout;
    logic                oe_n_ff;
    logic                nxt_oe_n;
    logic                pulse_ff;
    logic                nxt_pulse;
    logic                wr_en;

    // ------------------------------------------------------------------
    // access decode
    // ------------------------------------------------------------------
    logic is_cfg;
    logic is_prog;
    logic is_id;
    logic access_ok;

    // stored bit and live address feed every check
    ccg_access_gate #(
        .PROG_WORDS (PROG_WORDS),
        .HAS_CAL    (HAS_CAL)
    ) u_gate (
        .i_addr             (addr_ff),
        .i_code_protect_bit (cfg_ff[ccg_pkg::PROTECT_BIT]),
        .o_is_cfg           (is_cfg),
        .o_is_prog          (is_prog),
        .o_is_id            (is_id),
        .o_access_ok        (access_ok)
    );

    wire [PIDX_W-1:0] pidx = addr_ff[PIDX_W-1:0];
    wire [1:0]        iidx = addr_ff[1:0];

    // raw stored word; reserved addresses read zero
    wire [11:0] rd_raw = is_cfg  ? cfg_ff
                       : is_prog ? prog_mem[pidx]
                       : is_id   ? id_mem[iidx]
                       : ccg_pkg::WORD_ZERO;

    // protected words come back as zeros, never the stored value
    wire [11:0] rd_gated = access_ok ? rd_raw : ccg_pkg::WORD_ZERO;
    // core is twelve bits, so the top two serial bits read zero
    wire [13:0] rd_word  = {2'b00, rd_gated};

    // command assembled lsb first; the current bit enters at the top
    wire [5:0] cmd_word  = {sdat_s, cmd_ff[5:1]};
    wire       data_slot = (cnt_ff >= ccg_pkg::DATA_FIRST)
                        && (cnt_ff <= ccg_pkg::DATA_LAST);
    wire [3:0] cnt_inc   = cnt_ff + ccg_pkg::CNT_STEP;

    // ------------------------------------------------------------------
    // serial protocol next state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        nxt_cmd   = cmd_ff;
        nxt_addr  = addr_ff;
        nxt_load  = load_ff;
        nxt_shift = shift_ff;
        nxt_dout  = dout_ff;
        nxt_oe_n  = oe_n_ff;
        nxt_pulse = pulse_ff;
        wr_en     = 1'b0;
        case (state_ff)
            ccg_pkg::CCG_ST_CMD: begin
                if (sclk_fall) begin
                    nxt_cmd = cmd_word;
                    nxt_cnt = cnt_inc;
                    if (cnt_ff == ccg_pkg::CMD_LAST) begin
                        nxt_cnt = ccg_pkg::CNT_ZERO;
                        // unknown commands are dropped silently
                        if (cmd_word == ccg_pkg::CMD_LOAD) begin
                            nxt_state = ccg_pkg::CCG_ST_LOAD;
                        end else if (cmd_word == ccg_pkg::CMD_READ) begin
                            nxt_state = ccg_pkg::CCG_ST_READ;
                            nxt_shift = rd_word;
                        end else if (cmd_word == ccg_pkg::CMD_INC) begin
                            nxt_addr = addr_ff + ccg_pkg::ADDR_STEP;
                        end else if (cmd_word == ccg_pkg::CMD_BEGIN) begin
                            // blocked words get neither write nor pulse
                            wr_en     = access_ok;
                            nxt_pulse = access_ok;
                        end else if (cmd_word == ccg_pkg::CMD_END) begin
                            nxt_pulse = 1'b0;
                        end
                    end
                end
            end
            ccg_pkg::CCG_ST_LOAD: begin
                if (sclk_fall) begin
                    nxt_cnt = cnt_inc;
                    // start and stop cycles carry no data
                    if (data_slot) begin
                        nxt_load = {sdat_s, load_ff[13:1]};
                    end
                    if (cnt_ff == ccg_pkg::FRAME_LAST) begin
                        nxt_cnt   = ccg_pkg::CNT_ZERO;
                        nxt_state = ccg_pkg::CCG_ST_CMD;
                    end
                end
            end
            ccg_pkg::CCG_ST_READ: begin
                if (sclk_rise) begin
                    if (data_slot) begin
                        nxt_dout  = shift_ff[0];
                        nxt_shift = {1'b0, shift_ff[13:1]};
                        nxt_oe_n  = 1'b0;
                    end else if (cnt_ff == ccg_pkg::FRAME_LAST) begin
                        nxt_oe_n  = 1'b1;
                    end
                end
                if (sclk_fall) begin
                    nxt_cnt = cnt_inc;
                    if (cnt_ff == ccg_pkg::FRAME_LAST) begin
                        nxt_cnt   = ccg_pkg::CNT_ZERO;
                        nxt_oe_n  = 1'b1;
                        nxt_state = ccg_pkg::CCG_ST_CMD;
                    end
                end
            end
            default: begin
                nxt_state = ccg_pkg::CCG_ST_CMD;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // control flops
    // ------------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            state_ff <= ccg_pkg::CCG_ST_CMD;
            cnt_ff   <= ccg_pkg::CNT_ZERO;
            cmd_ff   <= 6'h00;
            addr_ff  <= ccg_pkg::ADDR_RESET;
            load_ff  <= 14'h0000;
            shift_ff <= 14'h0000;
            dout_ff  <= 1'b0;
            oe_n_ff  <= 1'b1;
            pulse_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            cmd_ff   <= nxt_cmd;
            addr_ff  <= nxt_addr;
            load_ff  <= nxt_load;
            shift_ff <= nxt_shift;
            dout_ff  <= nxt_dout;
            oe_n_ff  <= nxt_oe_n;
            pulse_ff <= nxt_pulse;
        end
    end

    // ------------------------------------------------------------------
    // configuration word; a fresh mode entry starts it blank
    // ------------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            cfg_ff <= ccg_pkg::CFG_BLANK;
        end else if (wr_en && is_cfg) begin
            cfg_ff <= load_ff[11:0];
        end
    end

    // arrays carry no reset: contents are meant to persist
    always_ff @(posedge i_clock) begin
        if (wr_en && is_prog) begin
            prog_mem[pidx] <= load_ff[11:0];
        end
        if (wr_en && is_id) begin
            id_mem[iidx] <= load_ff[11:0];
        end
    end

    // ------------------------------------------------------------------
    // configuration decode
    // ------------------------------------------------------------------
    wire [1:0] osc_sel = {cfg_ff[ccg_pkg::OSC_HI_BIT],
                          cfg_ff[ccg_pkg::OSC_LO_BIT]};
    wire master_clear_pin_en = cfg_ff[ccg_pkg::MASTER_CLEAR_PIN_EN_BIT];

    // with the pin disabled, master clear is tied to supply
    assign o_core_reset_n = master_clear_pin_en ? master_clear_pin_ns : 1'b1;

    assign o_master_clear_pin_enable = master_clear_pin_en;
    assign o_code_protect_active     =
        (cfg_ff[ccg_pkg::PROTECT_BIT] == ccg_pkg::BIT_PROGRAMMED);
    assign o_watchdog_enable         = cfg_ff[ccg_pkg::WDOG_EN_BIT];
    assign o_oscillator_select_field = osc_sel;
    assign o_osc_ext_rc              = (osc_sel == ccg_pkg::OSC_EXT_RC);
    assign o_osc_int_rc              = (osc_sel == ccg_pkg::OSC_INT_RC);
    assign o_crystal_osc_mode        = (osc_sel == ccg_pkg::OSC_XTAL);
    assign o_low_power_crystal_mode  = (osc_sel == ccg_pkg::OSC_LP_XT);

    // port and status outputs
    assign o_prog_data      = dout_ff;
    assign o_prog_data_oe_n = oe_n_ff;
    assign o_address        = addr_ff;
    assign o_prog_pulse     = pulse_ff;
    assign o_access_denied  = !access_ok;

endmodule : ccg_top

`default_nettype wire

//--- ccg_monitor.sv
// port checker for the protection gate
`timescale 1ns/1ps
`default_nettype none

module ccg_checker #(
    parameter int unsigned PROG_WORDS = 512,
    parameter bit          HAS_CAL    = 1'b1
) (
    // clock and reset
    input wire logic        i_clock,
    input wire logic        i_rst_n,
    // decoded configuration
    input wire logic        o_core_reset_n,
    input wire logic        o_master_clear_pin_enable,
    input wire logic        o_code_protect_active,
    input wire logic        o_watchdog_enable,
    input wire logic [1:0]  o_oscillator_select_field,
    input wire logic        o_osc_ext_rc,
    input wire logic        o_osc_int_rc,
    input wire logic        o_crystal_osc_mode,
    input wire logic        o_low_power_crystal_mode,
    // programming status
    input wire logic [11:0] o_address,
    input wire logic        o_prog_pulse,
    input wire logic        o_access_denied
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    // ----------------
    // configuration decode
    // ----------------
    blank_after_reset_a: assert property (disable iff (1'b0)
        !i_rst_n |=> o_master_clear_pin_enable && o_watchdog_enable &&
        !o_code_protect_active && o_oscillator_select_field == 2'h3)
        else $error("config not blank");
    master_clear_pin_tied_high_a: assert property (
        !o_master_clear_pin_enable |-> o_core_reset_n)
        else $error("reset with pin off");
    rc_decode_a: assert property (
        o_osc_ext_rc == (o_oscillator_select_field == 2'h3) &&
        o_osc_int_rc == (o_oscillator_select_field == 2'h2))
        else $error("rc decode wrong");
    xtal_decode_a: assert property (
        o_crystal_osc_mode == (o_oscillator_select_field == 2'h1) &&
        o_low_power_crystal_mode == (o_oscillator_select_field == 2'h0))
        else $error("crystal decode wrong");

    // ----------------
    // address counter
    // ----------------
    addr_reset_a: assert property (disable iff (1'b0)
        !i_rst_n |=> o_address == 12'hFFF && !o_prog_pulse)
        else $error("address not 0xFFF");
    addr_step_a: assert property (
        $past(i_rst_n) && o_address != $past(o_address)
        |-> o_address == $past(o_address) + 12'h001)
        else $error("address skipped");

    // ----------------
    // region gating
    // ----------------
    low_block_open_a: assert property (
        o_address <= 12'h03F |-> !o_access_denied)
        else $error("low block denied");
    cfg_word_open_a: assert property (
        o_address == 12'hFFF |-> !o_access_denied)
        else $error("config denied");
    id_words_open_a: assert property (
        o_address >= PROG_WORDS && o_address < PROG_WORDS + 4
        |-> !o_access_denied)
        else $error("id word denied");
    cal_word_open_a: assert property (
        HAS_CAL && o_address == PROG_WORDS - 1 |-> !o_access_denied)
        else $error("cal word denied");
    prot_range_shut_a: assert property (
        o_code_protect_active && o_address >= 12'h040 &&
        o_address <= PROG_WORDS - 1 - HAS_CAL |-> o_access_denied)
        else $error("protected word open");
    unprot_open_a: assert property (
        !o_code_protect_active && o_address < PROG_WORDS
        |-> !o_access_denied)
        else $error("open word denied");
    denied_no_pulse_a: assert property (
        $rose(o_prog_pulse) |-> !o_access_denied)
        else $error("pulse on denied word");
endmodule : ccg_checker

bind ccg_top ccg_checker #(
    .PROG_WORDS(PROG_WORDS),
    .HAS_CAL   (HAS_CAL)
) ccg_checker_inst (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .o_address(o_address),
    .o_core_reset_n(o_core_reset_n), .o_prog_pulse(o_prog_pulse),
    .o_master_clear_pin_enable(o_master_clear_pin_enable),
    .o_code_protect_active(o_code_protect_active),
    .o_watchdog_enable(o_watchdog_enable),
    .o_oscillator_select_field(o_oscillator_select_field),
    .o_osc_ext_rc(o_osc_ext_rc), .o_osc_int_rc(o_osc_int_rc),
    .o_crystal_osc_mode(o_crystal_osc_mode),
    .o_low_power_crystal_mode(o_low_power_crystal_mode),
    .o_access_denied(o_access_denied)
);

`default_nettype wire

//--- ccg_prog_model.sv
// serial programmer model
`timescale 1ns/1ps
`default_nettype none

module ccg_prog_model (
    // clock
    input  wire logic i_clock,
    // device side of the data pin
    input  wire logic i_dev_data,
    input  wire logic i_dev_oe_n,
    // pins seen by the device
    output logic      o_prog_clk,
    output logic      o_pin
);
    localparam int HALF = 5;
    logic clk_ff = 1'b0;
    logic dat_ff = 1'b0;
    logic drv_ff = 1'b1;

    // released pin shows the inverse level
    assign o_prog_clk = clk_ff;
    assign o_pin = !i_dev_oe_n ? i_dev_data : drv_ff ? dat_ff : ~dat_ff;

    // one cycle; data moves at the rise
    task automatic cycle(input logic b);
        @(posedge i_clock);
        clk_ff <= 1'b1;
        dat_ff <= b;
        repeat (HALF) @(posedge i_clock);
        clk_ff <= 1'b0;
        repeat (HALF) @(posedge i_clock);
    endtask : cycle

    // six command bits, low bit first
    task automatic cmd(input logic [5:0] c);
        for (int i = 0; i < 6; i++) cycle(c[i]);
    endtask : cmd

    // start bit, 14 data bits, stop bit
    task automatic load(input logic [13:0] w);
        cycle(1'b0);
        for (int i = 0; i < 14; i++) cycle(w[i]);
        cycle(1'b0);
    endtask : load

    // pin released; bits sampled late in each high
    task automatic read(output logic [13:0] w, output logic oe_ok);
        drv_ff <= 1'b0;
        oe_ok = 1'b1;
        for (int k = 1; k <= 16; k++) begin
            @(posedge i_clock);
            clk_ff <= 1'b1;
            repeat (HALF) @(posedge i_clock);
            if (k >= 2 && k <= 15) begin
                w[k-2] = o_pin;
                oe_ok = oe_ok && (i_dev_oe_n === 1'b0);
            end
            clk_ff <= 1'b0;
            repeat (HALF) @(posedge i_clock);
        end
        drv_ff <= 1'b1;
    endtask : read
endmodule : ccg_prog_model

`default_nettype wire

//--- code_protect_config_gate_tb.sv
// self-checking bench for the protection gate
`timescale 1ns/1ps
`default_nettype none

module code_protect_config_gate_tb;
    // ----------------
    // signals
    // ----------------
    logic        i_clock              = 1'b0;
    logic        i_rst_n              = 1'b0;
    logic        i_master_clear_pin_n = 1'b1;
    logic        prog_clk;
    logic        pin;
    logic        o_prog_data;
    logic        o_prog_data_oe_n;
    logic        o_core_reset_n;
    logic        o_master_clear_pin_enable;
    logic        o_code_protect_active;
    logic        o_watchdog_enable;
    logic [1:0]  o_oscillator_select_field;
    logic        o_osc_ext_rc;
    logic        o_osc_int_rc;
    logic        o_crystal_osc_mode;
    logic        o_low_power_crystal_mode;
    logic [11:0] o_address;
    logic        o_prog_pulse;
    logic        o_access_denied;
    int          fails  = 0;
    int          checks = 0;
    logic [11:0] adr [8] = '{12'h000, 12'h03F, 12'h040, 12'h1FE,
                             12'h1FF, 12'h200, 12'h203, 12'h204};

    // 20 MHz clock
    always #25 i_clock = ~i_clock;

    ccg_top ccg_top_inst (
        .i_clock(i_clock), .i_rst_n(i_rst_n),
        .i_prog_clk(prog_clk), .i_prog_data(pin),
        .o_prog_data(o_prog_data), .o_prog_data_oe_n(o_prog_data_oe_n),
        .i_master_clear_pin_n(i_master_clear_pin_n),
        .o_core_reset_n(o_core_reset_n),
        .o_master_clear_pin_enable(o_master_clear_pin_enable),
        .o_code_protect_active(o_code_protect_active),
        .o_watchdog_enable(o_watchdog_enable),
        .o_oscillator_select_field(o_oscillator_select_field),
        .o_osc_ext_rc(o_osc_ext_rc), .o_osc_int_rc(o_osc_int_rc),
        .o_crystal_osc_mode(o_crystal_osc_mode),
        .o_low_power_crystal_mode(o_low_power_crystal_mode),
        .o_address(o_address), .o_prog_pulse(o_prog_pulse),
        .o_access_denied(o_access_denied)
    );

    ccg_prog_model ccg_prog_model_inst (
        .i_clock(i_clock), .i_dev_data(o_prog_data),
        .i_dev_oe_n(o_prog_data_oe_n), .o_prog_clk(prog_clk), .o_pin(pin)
    );

    // ----------------
    // compare and access tasks
    // ----------------
    task automatic chk_word(input logic [13:0] got, input logic [13:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %0t word %h not %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %0t bit %b not %b", $time, got, exp);
        end
    endtask : chk_bit

    task automatic rd(input logic [13:0] exp);
        logic [13:0] w;
        logic        ok;
        ccg_prog_model_inst.cmd(ccg_pkg::CMD_READ);
        ccg_prog_model_inst.read(w, ok);
        chk_word(w, exp);
        chk_bit(ok, 1'b1);
    endtask : rd

    // top two loaded bits set; they must be dropped
    task automatic wr(input logic [11:0] v, input logic pulse);
        ccg_prog_model_inst.cmd(ccg_pkg::CMD_LOAD);
        ccg_prog_model_inst.load({2'b11, v});
        ccg_prog_model_inst.cmd(ccg_pkg::CMD_BEGIN);
        chk_bit(o_prog_pulse, pulse);
        ccg_prog_model_inst.cmd(ccg_pkg::CMD_END);
    endtask : wr

    // bounded walk of the address
    task automatic inc_to(input logic [11:0] t);
        for (int n = 0; n < 1100 && o_address !== t; n++)
            ccg_prog_model_inst.cmd(ccg_pkg::CMD_INC);
        chk_word({2'b00, o_address}, {2'b00, t});
    endtask : inc_to

    // reset held for two edges
    task automatic do_reset;
        @(posedge i_clock);
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_clock);
        i_rst_n <= 1'b1;
        repeat (4) @(posedge i_clock);
    endtask : do_reset

    task automatic summarize;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize

    // ----------------
    // tests
    // ----------------
    initial begin
        logic [11:0] v;
        logic        op;
        do_reset;
        chk_word({2'b00, o_address}, 14'h0FFF);
        rd(14'h0FFF);
        for (int i = 0; i < 4; i++) begin
            v = {7'h7F, i[1], 1'b1, i[0], i[1:0]};
            wr(v, 1'b1);
            chk_word({12'h000, o_oscillator_select_field}, {12'h000, v[1:0]});
            chk_word({10'h000, o_osc_ext_rc, o_osc_int_rc,
                o_crystal_osc_mode, o_low_power_crystal_mode}, 14'(1 << i));
            chk_bit(o_watchdog_enable, v[2]);
            chk_bit(o_master_clear_pin_enable, v[4]);
            i_master_clear_pin_n <= 1'b0;
            repeat (6) @(posedge i_clock);
            chk_bit(o_core_reset_n, !v[4]);
            i_master_clear_pin_n <= 1'b1;
            rd({2'b00, v});
        end
        chk_bit(o_code_protect_active, 1'b0);
        for (int j = 0; j < 8; j++) begin
            inc_to(adr[j]);
            wr(adr[j] ^ 12'h5A5, j != 7);
            chk_bit(o_access_denied, j == 7);
            rd(j != 7 ? {2'b00, adr[j] ^ 12'h5A5} : 14'h0000);
        end
        do_reset;
        wr(12'hFF7, 1'b1);
        chk_bit(o_code_protect_active, 1'b1);
        rd(14'h0FF7);
        for (int j = 0; j < 8; j++) begin
            op = j != 2 && j != 3 && j != 7;
            inc_to(adr[j]);
            wr(adr[j] ^ 12'hA5A, op);
            chk_bit(o_access_denied, !op);
            rd(op ? {2'b00, adr[j] ^ 12'hA5A} : 14'h0000);
        end
        do_reset;
        inc_to(12'h040);
        rd({2'b00, 12'h040 ^ 12'h5A5});
        summarize;
    end

    // watchdog: normal run is under 90000 cycles
    initial begin
        repeat (95000) @(posedge i_clock);
        fails++;
        summarize;
    end
endmodule : code_protect_config_gate_tb

`default_nettype wire
